// ---- core/csp_cfg.svh ----
// constants of the cascaded codec serial port
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CSP_MCLK_NS        40
`define CSP_SCLK_HALF_NS   80
`define CSP_SCLK_HALF_CYC  ((`CSP_SCLK_HALF_NS + `CSP_MCLK_NS - 1) / `CSP_MCLK_NS)
`define CSP_WORD_BITS      16
`define CSP_FIFO_DEPTH     16

// ----------------------------------------
// control word fields
// ----------------------------------------
`define CSP_CW_CTL         15
`define CSP_CW_ADDR_HI     14
`define CSP_CW_ADDR_LO     12
`define CSP_CW_REG_HI      11
`define CSP_CW_REG_LO      8
`define CSP_REG_PRIMARY    4'h0
`define CSP_REG_RATE       4'h1

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define CSP_PCR_DATA       0
`define CSP_PCR_MIXED      1
`define CSP_PCR_DC_HI      4
`define CSP_PCR_DC_LO      2
`define CSP_RATE_HI        1
`define CSP_RATE_LO        0
`define CSP_DIV_HI         4
`define CSP_DIV_LO         2
`define CSP_DC_RST         3'h0
`define CSP_DIV_RST        3'h0
`define CSP_RATE_RST       2'h0
`define CSP_DEF_PERIOD     12'h800

`endif

// ---- core/csp_pkg.sv ----
// types shared by both ends of the serial port
package csp_pkg;

	typedef logic [15:0] csp_word_t;

	typedef enum logic [1:0] {
		csp_mode_program,
		csp_mode_data,
		csp_mode_mixed
	} csp_mode_t;

	// sample period in divided clock pulses: code 0 slowest, 3 fastest
	function automatic logic [11:0] csp_period(input logic [1:0] code);
		csp_period = 12'h800 >> code;
	endfunction : csp_period

endpackage : csp_pkg

// ---- core/csp_link_if.sv ----
// serial link between the codec end and the dsp end
`timescale 1ns/100ps
interface csp_link_if;
	logic serial_clk;
	logic serial_out_frame_sync;
	logic serial_out_data;
	logic serial_in_data;
	logic dsp_frame_sync;
	logic direct_sel;
	logic serial_in_frame_sync;

	// directly coupled: codec output sync also frames the input words
	assign serial_in_frame_sync = direct_sel ? serial_out_frame_sync : dsp_frame_sync;

	modport codec (
		output serial_clk,
		output serial_out_frame_sync,
		output serial_out_data,
		input  serial_in_frame_sync,
		input  serial_in_data
	);

	modport dsp (
		input  serial_clk,
		input  serial_out_frame_sync,
		input  serial_out_data,
		output serial_in_data,
		output dsp_frame_sync,
		output direct_sel
	);
endinterface : csp_link_if

// ---- core/csp_fifo.sv ----
// word fifo with valid and ready on both sides
`timescale 1ns/100ps
module csp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	import csp_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	// honest flags from the occupancy count
	assign in_ready  = cnt_ff != DEPTH[AW:0];
	assign out_valid = cnt_ff != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_ready && out_valid;
	assign out_data  = mem_ff[rd_ff];

	// storage, no reset needed on data
	always_ff @(posedge mclk)
	begin
		if (push)
			mem_ff[wr_ff] <= in_data;
	end

	// pointers and count
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			if (pop)
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : csp_fifo

// ---- core/csp_codec_end.sv ----
// codec end of the serial port: clock source, framing, cascade logic
`timescale 1ns/100ps
`include "csp_cfg.svh"

// Functional notes
// - sync high one bit ahead or last bit
// - codec makes and drives serial clock
// - indirect: dsp makes its own input sync
// - direct: codec output sync frames input
// - dsp preloads first word before reset release
// - up to eight units, address inside words
// - units times sixteen times rate within clock
// - indirect cascade: dsp sends within sample interval
// - output word done sixteen clocks after sample; here sync bit first, done 17 to 18 clocks after
// - count input syncs, three bit device count
// - device count resets to zero, one unit
// - four sample rates, same modulator rate
// - master divider scales timing, resets divide-one
// - address zero accepts, else decrement and pass
// - own frame when sync count equals count
// - slow default rate until rate written
module csp_codec_end (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	csp_link_if.codec                 lnk,
	input  wire csp_pkg::csp_word_t   adc_data,
	output logic                      sample_evt,
	output csp_pkg::csp_word_t        dac_data,
	output logic                      dac_load,
	output csp_pkg::csp_mode_t        mode,
	output logic [2:0]                cascade_count_field,
	output logic [1:0]                rate_code,
	output logic [2:0]                mclk_div
);
	import csp_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [3:0]  sdiv_ff;
	logic        sclk_ff;
	logic        rise;
	logic        fall;
	logic [2:0]  mdiv_ff;
	logic        dm_en;
	logic [11:0] per_ff;
	logic [11:0] period;
	logic        rate_set_ff;
	csp_mode_t   mode_ff;
	logic [2:0]  dc_ff;
	logic [1:0]  rate_ff;
	logic [2:0]  div_ff;
	logic        rx_act_ff;
	logic [3:0]  rx_cnt_ff;
	csp_word_t   rx_sh_ff;
	csp_word_t   rx_word;
	logic        rx_done;
	logic [3:0]  frm_ff;
	logic        own;
	logic        is_ctl;
	logic [2:0]  cw_addr;
	logic [3:0]  cw_reg;
	csp_word_t   dac_ff;
	logic        dac_ld_ff;
	logic        tx_fs_ff;
	logic        tx_bit_ff;
	csp_word_t   tx_sh_ff;
	logic [4:0]  tx_cnt_ff;
	logic        tx_busy_ff;
	logic        smp_pend_ff;
	csp_word_t   smp_word_ff;
	logic        fwd_pend_ff;
	csp_word_t   fwd_word_ff;
	logic        pend;
	logic        go;
	csp_word_t   nxt_word;

	// ----------------------------------------
	// serial clock and sample timing
	// ----------------------------------------

	// serial clock from mclk directly, edges known one cycle ahead
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sdiv_ff <= '0;
			sclk_ff <= 1'b0;
		end
		else if (sdiv_ff == 4'(`CSP_SCLK_HALF_CYC - 1))
		begin
			sdiv_ff <= '0;
			sclk_ff <= ~sclk_ff;
		end
		else
			sdiv_ff <= sdiv_ff + 4'h1;
	end

	assign rise = (sdiv_ff == 4'(`CSP_SCLK_HALF_CYC - 1)) && !sclk_ff;
	assign fall = (sdiv_ff == 4'(`CSP_SCLK_HALF_CYC - 1)) && sclk_ff;
	assign lnk.serial_clk = sclk_ff;

	// divided master clock enable, divide by div_ff + 1
	always_ff @(posedge mclk)
	begin
		if (rst)
			mdiv_ff <= '0;
		else if (dm_en)
			mdiv_ff <= '0;
		else
			mdiv_ff <= mdiv_ff + 3'h1;
	end

	assign dm_en = mdiv_ff >= div_ff;

	// sample period: modulator rate fixed, only the decimation length varies
	assign period = rate_set_ff ? csp_period(rate_ff) : `CSP_DEF_PERIOD;

	always_ff @(posedge mclk)
	begin
		if (rst)
			per_ff <= '0;
		else if (dm_en)
			per_ff <= (per_ff >= period - 12'h001) ? '0 : per_ff + 12'h001;
	end

	assign sample_evt = dm_en && (per_ff >= period - 12'h001);

	// ----------------------------------------
	// input word receiver
	// ----------------------------------------
	assign rx_word = {rx_sh_ff[14:0], lnk.serial_in_data};
	assign rx_done = rise && rx_act_ff && (rx_cnt_ff == 4'hf);

	// a sync seen on the last bit chains the next word with no gap
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rx_act_ff <= 1'b0;
			rx_cnt_ff <= '0;
			rx_sh_ff  <= '0;
		end
		else if (rise)
		begin
			if (rx_act_ff)
			begin
				rx_sh_ff <= rx_word;
				if (rx_cnt_ff == 4'hf)
				begin
					rx_cnt_ff <= '0;
					rx_act_ff <= lnk.serial_in_frame_sync;
				end
				else
					rx_cnt_ff <= rx_cnt_ff + 4'h1;
			end
			else if (lnk.serial_in_frame_sync)
			begin
				rx_act_ff <= 1'b1;
				rx_cnt_ff <= '0;
			end
		end
	end

	// input frames counted since the last sample event
	always_ff @(posedge mclk)
	begin
		if (rst)
			frm_ff <= '0;
		else if (sample_evt)
			frm_ff <= '0;
		else if (rx_done && frm_ff != 4'hf)
			frm_ff <= frm_ff + 4'h1;
	end

	assign own     = frm_ff == {1'b0, dc_ff};
	assign is_ctl  = (mode_ff == csp_mode_program) ||
	                 (mode_ff == csp_mode_mixed && rx_word[`CSP_CW_CTL]);
	assign cw_addr = rx_word[`CSP_CW_ADDR_HI:`CSP_CW_ADDR_LO];
	assign cw_reg  = rx_word[`CSP_CW_REG_HI:`CSP_CW_REG_LO];

	// ----------------------------------------
	// control registers and dac update
	// ----------------------------------------

	// plain data mode locks the registers until the next reset
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mode_ff     <= csp_mode_program;
			dc_ff       <= `CSP_DC_RST;
			rate_ff     <= `CSP_RATE_RST;
			div_ff      <= `CSP_DIV_RST;
			rate_set_ff <= 1'b0;
		end
		else if (rx_done && is_ctl && cw_addr == 3'h0)
		begin
			if (cw_reg == `CSP_REG_PRIMARY)
			begin
				dc_ff <= rx_word[`CSP_PCR_DC_HI:`CSP_PCR_DC_LO];
				if (!rx_word[`CSP_PCR_DATA])
					mode_ff <= csp_mode_program;
				else if (rx_word[`CSP_PCR_MIXED])
					mode_ff <= csp_mode_mixed;
				else
					mode_ff <= csp_mode_data;
			end
			else if (cw_reg == `CSP_REG_RATE)
			begin
				rate_ff     <= rx_word[`CSP_RATE_HI:`CSP_RATE_LO];
				div_ff      <= rx_word[`CSP_DIV_HI:`CSP_DIV_LO];
				rate_set_ff <= 1'b1;
			end
		end
	end

	// dac word only from the frame whose index matches the count
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dac_ff    <= '0;
			dac_ld_ff <= 1'b0;
		end
		else
		begin
			dac_ld_ff <= rx_done && !is_ctl && own;
			if (rx_done && !is_ctl && own)
				dac_ff <= (mode_ff == csp_mode_mixed) ? {rx_word[14:0], 1'b0} : rx_word;
		end
	end

	// ----------------------------------------
	// output word transmitter
	// ----------------------------------------
	assign pend     = smp_pend_ff || fwd_pend_ff;
	assign go       = fall && tx_fs_ff;
	assign nxt_word = smp_pend_ff ? smp_word_ff : fwd_word_ff;

	// pending words; a new arrival wins over the clear of its flag
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			smp_pend_ff <= 1'b0;
			smp_word_ff <= '0;
			fwd_pend_ff <= 1'b0;
			fwd_word_ff <= '0;
		end
		else
		begin
			if (sample_evt)
			begin
				smp_pend_ff <= 1'b1;
				smp_word_ff <= (mode_ff == csp_mode_mixed) ? {1'b0, adc_data[15:1]} : adc_data;
			end
			else if (go && smp_pend_ff)
				smp_pend_ff <= 1'b0;
			if (rx_done && is_ctl && cw_addr != 3'h0)
			begin
				fwd_pend_ff <= 1'b1;
				fwd_word_ff <= {rx_word[15], cw_addr - 3'h1, rx_word[11:0]};
			end
			else if (go && !smp_pend_ff)
				fwd_pend_ff <= 1'b0;
		end
	end

	// shifter; sync goes up on the last bit when another word waits
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tx_fs_ff   <= 1'b0;
			tx_bit_ff  <= 1'b0;
			tx_sh_ff   <= '0;
			tx_cnt_ff  <= '0;
			tx_busy_ff <= 1'b0;
		end
		else if (fall)
		begin
			tx_fs_ff <= pend && !tx_fs_ff && (!tx_busy_ff || tx_cnt_ff >= 5'd15);
			if (tx_fs_ff)
			begin
				tx_bit_ff  <= nxt_word[15];
				tx_sh_ff   <= {nxt_word[14:0], 1'b0};
				tx_cnt_ff  <= 5'd1;
				tx_busy_ff <= 1'b1;
			end
			else if (tx_busy_ff && tx_cnt_ff == 5'd16)
			begin
				tx_busy_ff <= 1'b0;
				tx_bit_ff  <= 1'b0;
			end
			else if (tx_busy_ff)
			begin
				tx_bit_ff <= tx_sh_ff[15];
				tx_sh_ff  <= {tx_sh_ff[14:0], 1'b0};
				tx_cnt_ff <= tx_cnt_ff + 5'd1;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign lnk.serial_out_frame_sync = tx_fs_ff;
	assign lnk.serial_out_data       = tx_bit_ff;
	assign dac_data                  = dac_ff;
	assign dac_load                  = dac_ld_ff;
	assign mode                      = mode_ff;
	assign cascade_count_field       = dc_ff;
	assign rate_code                 = rate_ff;
	assign mclk_div                  = div_ff;
endmodule : csp_codec_end

// ---- core/csp_dsp_end.sv ----
// dsp end of the serial port: receiver and fifo-fed transmitter
`timescale 1ns/100ps
`include "csp_cfg.svh"
module csp_dsp_end (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	csp_link_if.dsp                   lnk,
	input  wire logic                 direct_mode,
	input  wire csp_pkg::csp_word_t   tx_data,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output csp_pkg::csp_word_t        rx_data,
	output logic                      rx_valid
);
	import csp_pkg::*;

	logic      sclk_q_ff;
	logic      rise;
	logic      fall;
	logic      dir_ff;
	logic      rx_act_ff;
	logic [3:0] rx_cnt_ff;
	csp_word_t rx_sh_ff;
	csp_word_t rx_word;
	csp_word_t rx_ff;
	logic      rx_v_ff;
	logic      fs_cap_ff;
	logic      own_fs_ff;
	logic      go;
	logic      tx_bit_ff;
	csp_word_t tx_sh_ff;
	logic [4:0] tx_cnt_ff;
	logic      tx_busy_ff;
	csp_word_t f_data;
	logic      f_valid;
	logic      f_pop;

	// ----------------------------------------
	// clock edges and coupling
	// ----------------------------------------

	// serial clock arrives as a synchronous input; edges found by delay
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sclk_q_ff <= 1'b0;
			dir_ff    <= 1'b0;
		end
		else
		begin
			sclk_q_ff <= lnk.serial_clk;
			dir_ff    <= direct_mode;
		end
	end

	assign rise = lnk.serial_clk && !sclk_q_ff;
	assign fall = !lnk.serial_clk && sclk_q_ff;
	assign lnk.direct_sel = dir_ff;

	// ----------------------------------------
	// receiver of codec output words
	// ----------------------------------------
	assign rx_word = {rx_sh_ff[14:0], lnk.serial_out_data};

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rx_act_ff <= 1'b0;
			rx_cnt_ff <= '0;
			rx_sh_ff  <= '0;
			rx_ff     <= '0;
			rx_v_ff   <= 1'b0;
			fs_cap_ff <= 1'b0;
		end
		else
		begin
			rx_v_ff <= 1'b0;
			if (rise)
			begin
				fs_cap_ff <= lnk.serial_out_frame_sync;
				if (rx_act_ff)
				begin
					rx_sh_ff <= rx_word;
					if (rx_cnt_ff == 4'hf)
					begin
						rx_ff     <= rx_word;
						rx_v_ff   <= 1'b1;
						rx_cnt_ff <= '0;
						rx_act_ff <= lnk.serial_out_frame_sync;
					end
					else
						rx_cnt_ff <= rx_cnt_ff + 4'h1;
				end
				else if (lnk.serial_out_frame_sync)
				begin
					rx_act_ff <= 1'b1;
					rx_cnt_ff <= '0;
				end
			end
		end
	end

	// ----------------------------------------
	// transmitter of codec input words
	// ----------------------------------------
	csp_fifo #(
		.WIDTH (`CSP_WORD_BITS),
		.DEPTH (`CSP_FIFO_DEPTH)
	) u_tx_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_pop)
	);

	// direct: codec sync starts us; indirect: own sync from fifo level
	assign go    = fall && (dir_ff ? fs_cap_ff : own_fs_ff);
	assign f_pop = go && f_valid;

	// empty fifo in direct mode sends a zero word, keeping frames aligned
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			own_fs_ff  <= 1'b0;
			tx_bit_ff  <= 1'b0;
			tx_sh_ff   <= '0;
			tx_cnt_ff  <= '0;
			tx_busy_ff <= 1'b0;
		end
		else if (fall)
		begin
			own_fs_ff <= !dir_ff && f_valid && !own_fs_ff &&
			             (!tx_busy_ff || tx_cnt_ff >= 5'd15);
			if (go)
			begin
				tx_bit_ff  <= f_valid && f_data[15];
				tx_sh_ff   <= f_valid ? {f_data[14:0], 1'b0} : '0;
				tx_cnt_ff  <= 5'd1;
				tx_busy_ff <= 1'b1;
			end
			else if (tx_busy_ff && tx_cnt_ff == 5'd16)
			begin
				tx_busy_ff <= 1'b0;
				tx_bit_ff  <= 1'b0;
			end
			else if (tx_busy_ff)
			begin
				tx_bit_ff <= tx_sh_ff[15];
				tx_sh_ff  <= {tx_sh_ff[14:0], 1'b0};
				tx_cnt_ff <= tx_cnt_ff + 5'd1;
			end
		end
	end

	assign lnk.serial_in_data = tx_bit_ff;
	assign lnk.dsp_frame_sync = own_fs_ff;
	assign rx_data            = rx_ff;
	assign rx_valid           = rx_v_ff;
endmodule : csp_dsp_end

// ---- testbench/csp_link_monitor.sv ----
// wire-level checker for the serial link between codec end and dsp end
`timescale 1ns/100ps
module csp_link_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic serial_clk,
	input wire logic serial_out_frame_sync,
	input wire logic serial_out_data,
	input wire logic serial_in_data,
	input wire logic dsp_frame_sync
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic [7:0] gap_ff;

	// cycles since last output sync; saturates so an idle link never wraps
	always_ff @(posedge mclk)
	begin
		if (rst || $rose(serial_out_frame_sync))
			gap_ff <= rst ? 8'hff : 8'h00;
		else if (gap_ff != 8'hff)
			gap_ff <= gap_ff + 8'h01;
	end

	sequence s_sclk_high;
		serial_clk [*2];
	endsequence

	sequence s_sclk_low;
		!serial_clk [*2];
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_sclk_period: assert property ($rose(serial_clk) |-> s_sclk_high ##1 s_sclk_low ##1 serial_clk)
		else $error("serial clock period is not two high two low");
	chk_sclk_reset_low: assert property (disable iff (1'b0) rst |=> !serial_clk)
		else $error("serial clock not low in reset");
	chk_out_bit_edge: assert property ($changed(serial_out_data) |-> $fell(serial_clk))
		else $error("output bit changed off a clock fall");
	chk_out_sync_edge: assert property ($rose(serial_out_frame_sync) |-> $fell(serial_clk))
		else $error("output sync raised off a clock fall");
	chk_out_sync_width: assert property ($rose(serial_out_frame_sync) |-> serial_out_frame_sync [*4])
		else $error("output sync shorter than one bit");
	chk_word_spacing: assert property ($rose(serial_out_frame_sync) |-> gap_ff >= 8'd63)
		else $error("output words closer than sixteen bits");
	chk_in_bit_edge: assert property ($changed(serial_in_data) |-> $past(serial_clk, 2) && !$past(serial_clk))
		else $error("input bit not one cycle after a clock fall");
	chk_in_sync_stable: assert property ($rose(serial_clk) |-> $stable(dsp_frame_sync))
		else $error("input sync moved at a clock rise");
	chk_in_sync_width: assert property ($rose(dsp_frame_sync) |-> dsp_frame_sync [*4])
		else $error("input sync shorter than one bit");
endmodule : csp_link_monitor

// ---- testbench/tb.sv ----
// top bench: codec end and dsp end joined by the link interface
`timescale 1ns/100ps
module tb;
	import csp_pkg::*;
	logic       mclk;
	logic       rst;
	logic       direct_mode;
	csp_word_t  adc_data;
	csp_word_t  tx_data;
	logic       tx_valid;
	logic       tx_ready;
	logic       sample_evt;
	csp_word_t  dac_data;
	logic       dac_load;
	csp_mode_t  mode;
	logic [2:0] cascade_count_field;
	logic [1:0] rate_code;
	logic [2:0] mclk_div;
	csp_word_t  rx_data;
	logic       rx_valid;
	csp_word_t  rxq[$];
	int         errors;
	int         check_count;
	int         loads;
	int         n;
	logic       hit;

	csp_link_if lnk ();
	csp_codec_end i_csp_codec_end (.mclk(mclk), .rst(rst), .lnk(lnk.codec), .adc_data(adc_data),
		.sample_evt(sample_evt), .dac_data(dac_data), .dac_load(dac_load), .mode(mode),
		.cascade_count_field(cascade_count_field), .rate_code(rate_code), .mclk_div(mclk_div));
	csp_dsp_end i_csp_dsp_end (.mclk(mclk), .rst(rst), .lnk(lnk.dsp), .direct_mode(direct_mode),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid));
	csp_link_monitor i_csp_link_monitor (.mclk(mclk), .rst(rst), .serial_clk(lnk.serial_clk),
		.serial_out_frame_sync(lnk.serial_out_frame_sync), .serial_out_data(lnk.serial_out_data),
		.serial_in_data(lnk.serial_in_data), .dsp_frame_sync(lnk.dsp_frame_sync));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one word into the dsp fifo; held until ready is seen at a falling edge
	task automatic push(input csp_word_t w);
		logic r;
		@(posedge mclk);
		tx_data  <= w;
		tx_valid <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(negedge mclk);
			r = tx_ready;
			@(posedge mclk);
		end
		tx_valid <= 1'b0;
	endtask : push

	task automatic wait_evt(input int k);
		repeat (k)
		begin
			do @(negedge mclk); while (sample_evt !== 1'b1);
		end
	endtask : wait_evt

	// mclk cycles between two sample events
	task automatic period(output int p);
		wait_evt(1);
		p = 0;
		do
		begin
			@(negedge mclk);
			p++;
		end
		while (sample_evt !== 1'b1);
	endtask : period

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// clock, collectors, watchdog
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// one-cycle pulses are sampled mid-cycle where they are settled
	always @(negedge mclk)
	begin
		if (rx_valid === 1'b1)
			rxq.push_back(rx_data);
		if (dac_load === 1'b1)
			loads++;
	end

	// whole run needs roughly 25k cycles; allow well over that
	initial
	begin
		#4000000;
		errors++;
		$display("watchdog expired");
		test_done();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		direct_mode = 1'b1;
		adc_data = 16'ha5c3;
		tx_data = 16'h0000;
		tx_valid = 1'b0;
		errors = 0;
		check_count = 0;
		loads = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		check("mode", 16'(mode), 16'(csp_mode_program));
		check("count", 16'(cascade_count_field), 16'h0000);
		check("divider", 16'(mclk_div), 16'h0000);
		period(n);
		check("default period", 16'(n), 16'h0800);
		$display("test defaults done");
		// rate writes travel in step with codec output words
		push(16'h0103);
		wait_evt(2);
		period(n);
		check("fast period", 16'(n), 16'h0100);
		push(16'h0107);
		wait_evt(2);
		period(n);
		check("divided period", 16'(n), 16'h0200);
		check("rate code", 16'(rate_code), 16'h0003);
		check("divider set", 16'(mclk_div), 16'h0001);
		$display("test rates done");
		rxq.delete();
		push(16'h1042);
		wait_evt(3);
		hit = 1'b0;
		foreach (rxq[i]) if (rxq[i] === 16'h0042) hit = 1'b1;
		check("forwarded word", 16'(hit), 16'h0001);
		$display("test forwarding done");
		// indirect coupling: dsp frames its own words
		@(posedge mclk);
		direct_mode <= 1'b0;
		push(16'h0005);
		wait_evt(2);
		check("data mode", 16'(mode), 16'(csp_mode_data));
		check("count set", 16'(cascade_count_field), 16'h0001);
		wait_evt(1);
		loads = 0;
		push(16'h1234);
		push(16'hbeef);
		repeat (300) @(negedge mclk);
		check("dac loads", 16'(loads), 16'h0001);
		check("dac word", dac_data, 16'hbeef);
		rxq.delete();
		wait_evt(2);
		check("adc word", rxq[$], adc_data);
		$display("test data mode done");
		// fill the fifo until it refuses, then let it drain
		@(posedge mclk);
		tx_valid <= 1'b1;
		n = 0;
		hit = 1'b1;
		while (hit && n < 40)
		begin
			tx_data <= 16'(n);
			@(negedge mclk);
			hit = tx_ready;
			@(posedge mclk);
			if (hit)
				n++;
		end
		tx_valid <= 1'b0;
		check("fifo fill", 16'(n >= 16 && n <= 17), 16'h0001);
		repeat (1400) @(negedge mclk);
		check("fifo drained", 16'(tx_ready), 16'h0001);
		$display("test fifo done");
		// plain data mode locks the registers, so a reset reopens them for mixed mode
		@(posedge mclk);
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		check("mode after reset", 16'(mode), 16'(csp_mode_program));
		check("count after reset", 16'(cascade_count_field), 16'h0000);
		push(16'h0003);
		wait_evt(2);
		check("mixed mode", 16'(mode), 16'(csp_mode_mixed));
		wait_evt(1);
		loads = 0;
		push(16'h4321);
		repeat (300) @(negedge mclk);
		check("mixed dac loads", 16'(loads), 16'h0001);
		check("mixed dac word", dac_data, 16'h8642);
		rxq.delete();
		wait_evt(2);
		check("mixed adc word", rxq[$], 16'h52e1);
		$display("test mixed mode done");
		test_done();
	end
endmodule : tb
